// [rtl/ppc_pkg.sv]
// constants for the port 1 pin mode configuration block
package ppc_pkg;
    // register byte offset (printed offset is not a multiple of four: index)
    localparam logic [7:0] PPC_CONFIG_INDEX = 8'h9f;
    localparam logic [11:0] PPC_CONFIG_ADDR = 12'h27c;
    localparam logic [7:0] PPC_CONFIG_RESET = 8'h00;
    // field positions
    localparam int PPC_FUNC_HI = 7;
    localparam int PPC_FUNC_LO = 5;
    localparam int PPC_DIR_BIT = 4;
    localparam int PPC_LATCH_BIT = 3;
    localparam int PPC_INDEX_HI = 2;
    // mode encodings
    localparam logic [2:0] PPC_OUT_NORMAL = 3'h0;
    localparam logic [2:0] PPC_OUT_HIGH = 3'h3;
    localparam logic [1:0] PPC_IN_NOPULL = 2'h0;
    localparam logic [1:0] PPC_IN_PULLDOWN = 2'h1;
    localparam logic [1:0] PPC_IN_PULLUP = 2'h2;
    localparam logic [1:0] PPC_IN_OFF = 2'h3;
    // bus responses
    localparam logic [1:0] PPC_RESP_OKAY = 2'h0;
    localparam logic [1:0] PPC_RESP_SLVERR = 2'h2;
endpackage : ppc_pkg

// [rtl/ppc_port1_config.sv]
// AXI4-Lite slave holding the indirectly addressed port 1 pin mode settings
//
// Our own choice: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none

module ppc_port1_config
    import ppc_pkg::*;
(
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // write address
    input wire logic [11:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    // write data
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // write response
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // read address
    input wire logic [11:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    // read data
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // pad controls, one bit per pin
    output logic [7:0] out_high_drive,
    output logic [7:0] in_pull_down,
    output logic [7:0] in_pull_up,
    output logic [7:0] in_buffer_off
);

    logic [2:0] out_mode [8];
    logic [1:0] in_mode [8];
    logic [2:0] read_index;
    logic read_dir_input;
    logic [11:0] aw_addr;
    logic aw_held;
    logic [7:0] w_byte;
    logic w_lane0;
    logic w_held;
    logic do_write;
    // fields of the held write byte
    logic wr_accept;
    logic wr_latch;
    logic wr_dir_input;
    logic [2:0] wr_pin;
    logic [2:0] wr_func;

    // only the word index is decoded, so the two low address bits are ignored
    function automatic logic addr_hit(input logic [11:0] a);
        addr_hit = (a[11:2] == {2'h0, PPC_CONFIG_INDEX});
    endfunction : addr_hit

    // read value of one pin: mode in the function field, write-only fields zero
    function automatic logic [7:0] mode_byte(input logic dir_input, input logic [2:0] out_code,
                                             input logic [1:0] in_code);
        if (dir_input) begin
            mode_byte = {1'b0, in_code, 5'h00};
        end else begin
            mode_byte = {out_code, 5'h00};
        end
    endfunction : mode_byte

    // address and data taken in either order; response once both are held
    assign do_write = aw_held && w_held && !s_axi_bvalid;

    // a write acts only on the mapped word with byte lane 0 enabled
    assign wr_accept = do_write && addr_hit(aw_addr) && w_lane0;
    assign wr_latch = w_byte[PPC_LATCH_BIT];
    assign wr_dir_input = w_byte[PPC_DIR_BIT];
    assign wr_pin = w_byte[PPC_INDEX_HI:0];
    assign wr_func = w_byte[PPC_FUNC_HI:PPC_FUNC_LO];

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held <= 1'b0;
            aw_addr <= 12'h000;
            s_axi_awready <= 1'b0;
        end else if (do_write) begin
            aw_held <= 1'b0;
        end else if (s_axi_awvalid && s_axi_awready) begin
            aw_held <= 1'b1;
            aw_addr <= s_axi_awaddr;
            s_axi_awready <= 1'b0;
        end else begin
            s_axi_awready <= !aw_held && !s_axi_bvalid;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            w_held <= 1'b0;
            w_byte <= 8'h00;
            w_lane0 <= 1'b0;
            s_axi_wready <= 1'b0;
        end else if (do_write) begin
            w_held <= 1'b0;
        end else if (s_axi_wvalid && s_axi_wready) begin
            w_held <= 1'b1;
            w_byte <= s_axi_wdata[7:0];
            w_lane0 <= s_axi_wstrb[0];
            s_axi_wready <= 1'b0;
        end else begin
            s_axi_wready <= !w_held && !s_axi_bvalid;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= PPC_RESP_OKAY;
        end else if (do_write) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= addr_hit(aw_addr) ? PPC_RESP_OKAY : PPC_RESP_SLVERR;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // read pointer, loaded only by a latch write; modes stay untouched then
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            read_index <= PPC_CONFIG_RESET[PPC_INDEX_HI:0];
            read_dir_input <= PPC_CONFIG_RESET[PPC_DIR_BIT];
        end else if (wr_accept && wr_latch) begin
            read_index <= wr_pin;
            read_dir_input <= wr_dir_input;
        end
    end

    // output modes; illegal codes are stored as given and drive like normal
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            for (int i = 0; i < 8; i++) begin
                out_mode[i] <= PPC_OUT_NORMAL;
            end
        end else if (wr_accept && !wr_latch && !wr_dir_input) begin
            out_mode[wr_pin] <= wr_func;
        end
    end

    // input modes use only the two low bits of the function field
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            for (int i = 0; i < 8; i++) begin
                in_mode[i] <= PPC_IN_NOPULL;
            end
        end else if (wr_accept && !wr_latch && wr_dir_input) begin
            in_mode[wr_pin] <= wr_func[1:0];
        end
    end

    // pad decode, registered so the outputs come from flip-flops
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            out_high_drive <= 8'h00;
        end else begin
            for (int i = 0; i < 8; i++) begin
                out_high_drive[i] <= (out_mode[i] == PPC_OUT_HIGH);
            end
        end
    end

    // input pad controls; pull-up and pull-down never both from one code
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            in_pull_down <= 8'h00;
            in_pull_up <= 8'h00;
            in_buffer_off <= 8'h00;
        end else begin
            for (int i = 0; i < 8; i++) begin
                in_pull_down[i] <= (in_mode[i] == PPC_IN_PULLDOWN);
                in_pull_up[i] <= (in_mode[i] == PPC_IN_PULLUP);
                in_buffer_off[i] <= (in_mode[i] == PPC_IN_OFF);
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= PPC_RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= PPC_RESP_SLVERR;
            if (addr_hit(s_axi_araddr)) begin
                s_axi_rresp <= PPC_RESP_OKAY;
                s_axi_rdata[7:0] <= mode_byte(read_dir_input, out_mode[read_index],
                                              in_mode[read_index]);
            end
        end else if (s_axi_rvalid) begin
            if (s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end else begin
            s_axi_arready <= 1'b1;
        end
    end

endmodule : ppc_port1_config

`default_nettype wire

// [verification/ppc_port1_config_checker.sv]
// checker bound onto the pin mode block
`timescale 1ns/1ps
`default_nettype none
module ppc_port1_config_checker (
    input wire logic aclk, aresetn, s_axi_awready, s_axi_bvalid, s_axi_bready,
    input wire logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [7:0] out_high_drive, in_pull_down, in_pull_up, in_buffer_off
);
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    property p_bh; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid; endproperty
    a_bh: assert property (p_bh) else $error("bvalid");
    property p_bx; s_axi_bvalid |-> !s_axi_awready; endproperty
    a_bx: assert property (p_bx) else $error("awready");
    property p_rl; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid; endproperty
    a_rl: assert property (p_rl) else $error("rvalid");
    property p_rh; s_axi_rvalid && !s_axi_rready |=> $stable(s_axi_rdata); endproperty
    a_rh: assert property (p_rh) else $error("rdata");
    property p_rz; s_axi_rvalid |-> s_axi_rdata[4:0] == 5'h00; endproperty
    a_rz: assert property (p_rz) else $error("rdata low");
    property p_px; (in_pull_up & (in_pull_down | in_buffer_off)) == 8'h00; endproperty
    a_px: assert property (p_px) else $error("pull");
    // pads trail the mode store, so a change needs a write answer first
    property p_pc; $changed({out_high_drive, in_buffer_off}) |-> $past(s_axi_bvalid); endproperty
    a_pc: assert property (p_pc) else $error("pad");
    property p_po; $onehot0(in_pull_up ^ $past(in_pull_up)); endproperty
    a_po: assert property (p_po) else $error("pins");
    c_w: cover property (s_axi_bvalid && s_axi_bready);
    c_r: cover property (s_axi_rvalid && s_axi_rready);
    c_p: cover property ($changed(in_pull_down));
endmodule : ppc_port1_config_checker
bind ppc_port1_config ppc_port1_config_checker u_chk (.*);
`default_nettype wire

// [verification/ppc_port1_config_tb.sv]
// self-checking bench for the pin mode block
`timescale 1ns/1ps
`default_nettype none
module ppc_port1_config_tb import ppc_pkg::*; ();
    logic aclk = 0, aresetn = 0, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
    logic s_axi_arvalid = 0, s_axi_rready = 0, s_axi_awready, s_axi_wready, s_axi_bvalid;
    logic s_axi_arready, s_axi_rvalid;
    logic [11:0] s_axi_awaddr = '0, s_axi_araddr = '0;
    logic [31:0] s_axi_wdata = '0, s_axi_rdata;
    logic [3:0] s_axi_wstrb = '0;
    logic [1:0] s_axi_bresp, s_axi_rresp, im [8];
    logic [7:0] out_high_drive, in_pull_down, in_pull_up, in_buffer_off;
    logic [2:0] om [8], f;
    logic [33:0] q [$];
    logic [1:0] qb [$];
    int err_count = 0, n_tests = 0;
    ppc_port1_config dut_u (.*);
    initial forever #12.5 aclk = ~aclk;
    task automatic chk(input logic [33:0] s, e);
        n_tests++;
        err_count += int'(s !== e);
        if (s !== e) $display("unexpected %0t %h %h", $time, s, e);
    endtask : chk
    task automatic finish_test;
        $display("checks %0d errors %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : finish_test
    // both channels offered together, each dropped once it is taken
    task automatic wr(input logic [11:0] a, input logic [7:0] d, input logic s, logic [1:0] r);
        bit [1:0] t = 0;
        qb.push_back(r);
        @(posedge aclk);
        {s_axi_awaddr, s_axi_wdata, s_axi_wstrb} <= {a, 24'h00_0000, d, 3'h7, s};
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
        while (t != 2'h3) begin
            @(posedge aclk);
            t = t | {s_axi_awready, s_axi_wready};
            {s_axi_awvalid, s_axi_wvalid} <= ~t;
        end
        while (!s_axi_bvalid) @(posedge aclk);
        s_axi_bready <= 0;
    endtask : wr
    task automatic rd(input logic [11:0] a, input logic [33:0] e);
        q.push_back(e);
        @(posedge aclk);
        {s_axi_araddr, s_axi_arvalid, s_axi_rready} <= {a, 2'h3};
        do @(posedge aclk); while (!s_axi_arready);
        s_axi_arvalid <= 0;
        do @(posedge aclk); while (!s_axi_rvalid);
        s_axi_rready <= 0;
    endtask : rd
    always @(posedge aclk) if (s_axi_rvalid === 1'b1 && s_axi_rready === 1'b1)
        chk({s_axi_rresp, s_axi_rdata}, q.pop_front());
    always @(posedge aclk) if (s_axi_bvalid === 1'b1 && s_axi_bready === 1'b1)
        chk(s_axi_bresp, qb.pop_front());
    initial begin
        void'($urandom(14556));
        repeat (8) @(posedge aclk);
        aresetn <= 1;
        rd(PPC_CONFIG_ADDR, '0);
        for (int i = 0; i < 8; i++) begin
            om[i] = $urandom_range(1) ? PPC_OUT_HIGH : PPC_OUT_NORMAL;
            im[i] = 2'($urandom);
            wr(PPC_CONFIG_ADDR, {om[i], 2'h0, 3'(i)}, 1'b1, PPC_RESP_OKAY);
            wr(PPC_CONFIG_ADDR, {1'b0, im[i], 2'h2, 3'(i)}, 1'b1, PPC_RESP_OKAY);
        end
        for (int k = 0; k < 16; k++) begin
            wr(PPC_CONFIG_ADDR, {3'($urandom), k[3], 1'b1, 3'(k)}, 1'b1, PPC_RESP_OKAY);
            f = k[3] ? {1'b0, im[k[2:0]]} : om[k[2:0]];
            rd(PPC_CONFIG_ADDR, {26'h000_0000, f, 5'h00});
        end
        f = om[0] ^ 3'h3;
        wr(12'h280, {f, 5'h00}, 1'b1, PPC_RESP_SLVERR);
        wr(PPC_CONFIG_ADDR, {f, 5'h00}, 1'b0, PPC_RESP_OKAY);
        rd(12'h280, {PPC_RESP_SLVERR, 32'h0000_0000});
        repeat (2) @(posedge aclk);
        for (int i = 0; i < 8; i++)
            chk({out_high_drive[i], in_pull_down[i], in_pull_up[i], in_buffer_off[i]},
                {om[i] == PPC_OUT_HIGH, im[i] == PPC_IN_PULLDOWN,
                 im[i] == PPC_IN_PULLUP, im[i] == PPC_IN_OFF});
        finish_test;
    end
    initial begin
        #100us err_count++;
        finish_test;
    end
endmodule : ppc_port1_config_tb
`default_nettype wire
